// file: src/fpw_fan_pwm.sv
// Fan PWM generator with APB register access.
// Assumes APB3 master on the same clock; inputs synchronous to clk.
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Without high-resolution mode, use 6-bit duty and 5-bit frequency code.
// - High-resolution needs select bit 4 set in enhanced config register.
// - High-resolution also needs slow clock select bit 3 cleared.
// - High-resolution also needs frequency register equal 0x08; all three together.
// - High-resolution uses 8-bit duty, FF is full, 22.5 kHz output; code gives about 24.5 kHz, as HR_DIV rounds down to 4.
// - Low-resolution code N gives period 2N fast ticks, duty 2N is full.
// - Slow clock selected gives 1.4 kHz divided by 2N.
// - Low-resolution duty step is one part in 2N.
// - Duty cycle equals duty value over full-scale value.
module fpw_fan_pwm #(
  parameter int unsigned FAST_DIV = fpw_pkg::FAST_DIV,
  parameter int unsigned SLOW_DIV = fpw_pkg::SLOW_DIV,
  parameter int unsigned HR_DIV = fpw_pkg::HR_DIV
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Fan drive
  output logic fan_pwm
);

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] enh_cfg_q;
  logic [7:0] pwm_cfg_q;
  logic [7:0] duty_q;
  logic [7:0] freq_q;
  logic [15:0] div_q;
  logic [7:0] cnt_q;
  logic pwm_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  logic high_res;
  logic slow_sel;
  logic tick;
  logic [15:0] div_max;
  logic [7:0] period;
  logic [7:0] duty_eff;
  logic pwm_d;
  logic [15:0] div_d;
  logic [7:0] cnt_d;

  // APB decode and next values
  logic apb_setup;
  logic apb_commit;
  logic sel_enh_cfg;
  logic sel_pwm_cfg;
  logic sel_duty;
  logic sel_freq;
  logic sel_status;
  logic sel_any;
  logic [7:0] enh_cfg_d;
  logic [7:0] pwm_cfg_d;
  logic [7:0] duty_d;
  logic [7:0] freq_d;
  logic [7:0] status_rd;
  logic [31:0] prdata_d;
  logic pready_d;
  logic pslverr_d;

  function automatic logic addr_hit(input logic [11:0] a, input logic [7:0] idx);
    addr_hit = (a == {2'b00, idx, 2'b00});
  endfunction

  // ****************************************
  // Mode decode
  // ****************************************
  assign slow_sel = pwm_cfg_q[fpw_pkg::BIT_PWM_SLOW_CLOCK_SELECT];
  assign high_res = enh_cfg_q[fpw_pkg::BIT_HIGH_RES_DUTY_SELECT]
                    & ~slow_sel
                    & (freq_q == fpw_pkg::HR_FREQ_CODE);

  // High resolution is never entered on the slow clock
  always_comb begin
    if (high_res) begin
      div_max = 16'(HR_DIV);
    end else if (slow_sel) begin
      div_max = 16'(SLOW_DIV);
    end else begin
      div_max = 16'(FAST_DIV);
    end
  end

  // Compare with >= so a shorter rate after a mode switch wraps at once
  assign tick = (div_q >= div_max - 16'h0001);

  always_comb begin
    if (tick) begin
      div_d = 16'h0000;
    end else begin
      div_d = div_q + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= div_d;
    end
  end

  // ****************************************
  // Period and duty
  // ****************************************
  always_comb begin
    if (high_res) begin
      period = fpw_pkg::HR_FULL_DUTY;
      duty_eff = duty_q;
    end else begin
      period = {2'b00, freq_q[4:0], 1'b0};
      duty_eff = {2'b00, duty_q[5:0]};
    end
  end

  // Code 0 has no defined period, so the output is held low
  always_comb begin
    if (period == 8'h00) begin
      pwm_d = 1'b0;
    end else if (duty_eff >= period) begin
      pwm_d = 1'b1;
    end else begin
      pwm_d = (cnt_q < duty_eff);
    end
  end

  // Counter restarts if the period shrinks beneath it
  always_comb begin
    if (!tick) begin
      cnt_d = cnt_q;
    end else if (cnt_q >= period - 8'h01) begin
      cnt_d = 8'h00;
    end else begin
      cnt_d = cnt_q + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pwm_q <= 1'b0;
    end else begin
      pwm_q <= pwm_d;
    end
  end

  // ****************************************
  // APB slave
  // ****************************************
  function automatic logic [31:0] word8(input logic [7:0] v);
    word8 = {24'h000000, v};
  endfunction

  // Setup phase is decoded; the write commits at the access edge
  assign apb_setup = psel && !penable && !pready_q;
  assign apb_commit = psel && penable && pready_q;

  assign sel_enh_cfg = addr_hit(paddr, fpw_pkg::IDX_ENH_CFG);
  assign sel_pwm_cfg = addr_hit(paddr, fpw_pkg::IDX_PWM_CFG);
  assign sel_duty = addr_hit(paddr, fpw_pkg::IDX_DUTY);
  assign sel_freq = addr_hit(paddr, fpw_pkg::IDX_FREQ);
  assign sel_status = addr_hit(paddr, fpw_pkg::IDX_STATUS);
  assign sel_any = sel_enh_cfg || sel_pwm_cfg || sel_duty || sel_freq || sel_status;

  // Status is read only: live mode and the registered output level
  always_comb begin
    status_rd = 8'h00;
    status_rd[fpw_pkg::BIT_STAT_HR_ACTIVE] = high_res;
    status_rd[fpw_pkg::BIT_STAT_PWM_LEVEL] = pwm_q;
  end

  // ****************************************
  // APB answer
  // ****************************************
  // No wait state: answer decoded in setup, given in the first access cycle
  assign pready_d = apb_setup;
  assign pslverr_d = apb_setup && !sel_any;

  // Read data holds until the next setup, so a late look still sees it
  always_comb begin
    prdata_d = prdata_q;
    if (apb_setup) begin
      if (pwrite) begin
        prdata_d = 32'h00000000;
      end else if (sel_enh_cfg) begin
        prdata_d = word8(enh_cfg_q);
      end else if (sel_pwm_cfg) begin
        prdata_d = word8(pwm_cfg_q);
      end else if (sel_duty) begin
        prdata_d = word8(duty_q);
      end else if (sel_freq) begin
        prdata_d = word8(freq_q);
      end else if (sel_status) begin
        prdata_d = word8(status_rd);
      end else begin
        prdata_d = 32'h00000000;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= pready_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pslverr_q <= 1'b0;
    end else begin
      pslverr_q <= pslverr_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prdata_q <= 32'h00000000;
    end else begin
      prdata_q <= prdata_d;
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  // Writes land only at the completing access edge
  always_comb begin
    enh_cfg_d = enh_cfg_q;
    pwm_cfg_d = pwm_cfg_q;
    duty_d = duty_q;
    freq_d = freq_q;
    if (apb_commit && pwrite) begin
      if (sel_enh_cfg) begin
        enh_cfg_d = pwdata[7:0];
      end
      if (sel_pwm_cfg) begin
        pwm_cfg_d = pwdata[7:0];
      end
      if (sel_duty) begin
        duty_d = pwdata[7:0];
      end
      if (sel_freq) begin
        freq_d = pwdata[7:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      enh_cfg_q <= fpw_pkg::RST_ENH_CFG;
    end else begin
      enh_cfg_q <= enh_cfg_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pwm_cfg_q <= fpw_pkg::RST_PWM_CFG;
    end else begin
      pwm_cfg_q <= pwm_cfg_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      duty_q <= fpw_pkg::RST_DUTY;
    end else begin
      duty_q <= duty_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      freq_q <= fpw_pkg::RST_FREQ;
    end else begin
      freq_q <= freq_d;
    end
  end

  // Every output comes straight from a flip-flop
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign fan_pwm = pwm_q;

endmodule // fpw_fan_pwm

`default_nettype wire

// file: src/fpw_pkg.sv
// Constants for the fan PWM duty and frequency block.
// Assumes a 25 MHz system clock and an APB3 register slave.
package fpw_pkg;

  // ****************************************
  // Clock and internal time bases
  // ****************************************
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned FAST_CLK_HZ = 360000;
  localparam int unsigned SLOW_CLK_HZ = 1400;
  localparam int unsigned HR_PWM_HZ = 22500;
  localparam int unsigned HR_PERIOD_STEPS = 255;
  // Longest period whose rate is not below each target rate, so round down
  localparam int unsigned FAST_DIV = CLK_HZ / FAST_CLK_HZ;
  localparam int unsigned SLOW_DIV = CLK_HZ / SLOW_CLK_HZ;
  localparam int unsigned HR_DIV = CLK_HZ / (HR_PWM_HZ * HR_PERIOD_STEPS);

  // ****************************************
  // Register indices, byte address is index times four
  // ****************************************
  localparam logic [7:0] IDX_ENH_CFG = 8'h45;
  localparam logic [7:0] IDX_PWM_CFG = 8'h4a;
  localparam logic [7:0] IDX_DUTY = 8'h4c;
  localparam logic [7:0] IDX_FREQ = 8'h4d;
  localparam logic [7:0] IDX_STATUS = 8'h4f;

  // ****************************************
  // Field positions and values
  // ****************************************
  localparam int unsigned BIT_HIGH_RES_DUTY_SELECT = 4;
  localparam int unsigned BIT_PWM_SLOW_CLOCK_SELECT = 3;
  localparam logic [7:0] HR_FREQ_CODE = 8'h08;
  localparam logic [7:0] HR_FULL_DUTY = 8'hff;
  localparam int unsigned BIT_STAT_HR_ACTIVE = 0;
  localparam int unsigned BIT_STAT_PWM_LEVEL = 1;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_ENH_CFG = 8'h00;
  localparam logic [7:0] RST_PWM_CFG = 8'h00;
  localparam logic [7:0] RST_DUTY = 8'h00;
  localparam logic [7:0] RST_FREQ = 8'h08;

endpackage

// file: verif/fpw_fan_model.sv
// Fan PWM input model: counts cycles with the drive high.
// Assumes fan_pwm is a registered level on clk.
`timescale 1ns/1ps
`default_nettype none
module fpw_fan_model (
  // Clock and control
  input wire logic clk,
  input wire logic clr,
  // Fan drive
  input wire logic fan_pwm,
  output logic [15:0] hi_cnt
);
  // Window must span whole periods, so phase does not matter
  always_ff @(posedge clk) begin
    if (clr) hi_cnt <= 16'h0;
    else if (fan_pwm) hi_cnt <= hi_cnt + 16'h1;
  end
endmodule // fpw_fan_model
`default_nettype wire

// file: verif/fpw_fan_pwm_properties.sv
// APB handshake checks for the fan PWM block.
// Assumes one access cycle per transfer.
`timescale 1ns/1ps
`default_nettype none
module fpw_fan_pwm_properties (
  // Ports watched
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic hit;
  assign hit = paddr inside {12'h114, 12'h128, 12'h130, 12'h134, 12'h13c};
  sequence setup_s;
    psel && !penable;
  endsequence
  ready_after_setup_a: assert property (setup_s |=> pready) else $error("no ready after setup");
  ready_one_a: assert property (pready |=> !pready) else $error("ready too long");
  ready_cause_a: assert property (pready |-> $past(psel && !penable)) else $error("ready without setup");
  err_needs_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
  unmapped_err_a: assert property (setup_s and !hit |=> pslverr) else $error("no error");
  mapped_ok_a: assert property (setup_s and hit |=> !pslverr) else $error("false error");
  upper_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper bits");
  err_read_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("error data");
endmodule // fpw_fan_pwm_properties
bind fpw_fan_pwm fpw_fan_pwm_properties fpw_fan_pwm_properties_i (.clk(clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

// file: verif/fpw_fan_pwm_tb.sv
// Testbench: APB set-up, then high time over two periods.
// Assumes dividers shortened to 2, 5 and 1.
`timescale 1ns/1ps
`default_nettype none
module fpw_fan_pwm_tb;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, clr = 0, pready, pslverr, fan_pwm, er;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] hi_cnt;
  int error_cnt = 0, compares = 0;
  // Rows: enh, pwm cfg, freq, duty, period, high
  logic [32:0] t[11][6] = '{'{0,0,2,3,8,6}, '{0,0,31,62,124,124}, '{0,0,3,63,12,12}, '{0,0,8,197,32,10},
    '{0,8,1,1,10,5}, '{16,0,8,191,255,191}, '{16,8,8,191,80,80}, '{16,0,9,133,36,10},
    '{16,0,8,255,255,255}, '{0,0,0,5,20,0}, '{16,0,40,4,32,8}};
  logic [11:0] ra[5] = '{12'h114, 12'h128, 12'h130, 12'h134, 12'h13c};
  logic [32:0] rv[5] = '{0, 0, 0, 8, 0};
  fpw_fan_pwm #(.FAST_DIV(2), .SLOW_DIV(5), .HR_DIV(1)) fpw_fan_pwm_i (.clk, .rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .fan_pwm);
  fpw_fan_model fpw_fan_model_i (.clk, .clr, .fan_pwm, .hi_cnt);
  initial forever #20 clk = ~clk;
  task end_of_test;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [32:0] s, input logic [32:0] e);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %s exp %h seen %h", n, e, s);
    end
  endtask
  // Master holds the request until pready is seen high
  task apb(input logic w, input logic [11:0] a, input logic [32:0] d);
    int i;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d[31:0];
    @(posedge clk);
    penable <= 1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      error_cnt++;
      end_of_test;
    end
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    // Idle edge so the next call never reassigns psel in this time step
    @(posedge clk);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    for (int i = 0; i < 5; i++) begin
      apb(0, ra[i], 0);
      chk("reset value", rd, rv[i]);
    end
    apb(1, 12'h200, 33'h5a);
    chk("write error", er, 1);
    apb(0, 12'h200, 0);
    chk("unmapped read", {er, rd}, {1'b1, 32'h0});
    for (int i = 0; i < 11; i++) begin
      apb(1, 12'h114, t[i][0]);
      apb(1, 12'h128, t[i][1]);
      apb(1, 12'h134, t[i][2]);
      apb(1, 12'h130, t[i][3]);
      apb(0, 12'h130, 0);
      chk("duty", rd, t[i][3]);
      repeat (2 * t[i][4]) @(posedge clk);
      clr <= 1;
      @(posedge clk);
      clr <= 0;
      repeat (2 * t[i][4] + 1) @(posedge clk);
      chk("high time", {17'h0, hi_cnt}, 2 * t[i][5]);
      apb(0, 12'h13c, 0);
      chk("mode", rd[0], t[i][0] == 16 && t[i][1] == 0 && t[i][2] == 8);
      if (t[i][5] == 0 || t[i][5] == t[i][4]) chk("level", rd[1], t[i][5] != 0);
    end
    end_of_test;
  end
endmodule // fpw_fan_pwm_tb
`default_nettype wire
